// *** design/bsc_capture.v ***
// One-shot capture of strap levels at the first edge after a reset release
`timescale 1ns/1ns
`default_nettype none

module bsc_capture #(
	parameter         W         = 4,
	parameter [W-1:0] RESET_VAL = {W{1'b1}}
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] strap,
	output reg  [W-1:0] field_q,
	output reg          done_q
);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			field_q <= RESET_VAL;
			done_q  <= 1'b0;
		end else if (!done_q) begin
			field_q <= strap;
			done_q  <= 1'b1;
		end
	end
	// Held until this reset asserts again

endmodule // bsc_capture

`default_nettype wire

// *** design/bsc_regs.vh ***
// Register offsets, field positions and reset values of the boot strap capture block
`ifndef BSC_REGS_VH
`define BSC_REGS_VH

// ************************************************
// Register byte offsets
// ************************************************
`define BSC_CHIP_CONFIG_OFS   12'h000
`define BSC_PIN_CONFIG_OFS    12'h004
`define BSC_EXT_CH0_OFS       12'h008
`define BSC_STATUS_OFS        12'h00C

// ************************************************
// Strap vector positions (index = address line - 5)
// ************************************************
`define BSC_S_PCI_ROLE        14
`define BSC_S_SEL_A           13
`define BSC_S_TEST_HI         12
`define BSC_S_TEST_LO         10
`define BSC_S_SYS_SP_HI       9
`define BSC_S_SYS_SP_LO       8
`define BSC_S_ENDIAN          7
`define BSC_S_PCI_DIV_HI      6
`define BSC_S_PCI_DIV_LO      5
`define BSC_S_SEL_B           4
`define BSC_S_CH0_EN          3
`define BSC_S_CH0_SP_HI       2
`define BSC_S_CH0_SP_LO       1
`define BSC_S_DRIVE           0

// ************************************************
// chip_config_reg fields
// ************************************************
`define BSC_CC_ENDIAN         0
`define BSC_CC_SYS_SP_LO      1
`define BSC_CC_PCI_DIV_LO     3
`define BSC_CC_PCI_ROLE       5
`define BSC_CC_OVR_EN         12

// ************************************************
// pin_config_reg fields
// ************************************************
`define BSC_PC_SEL_A          0
`define BSC_PC_SEL_B          1
`define BSC_PC_DRIVE          2
`define BSC_PC_OVR_VAL        3

// ************************************************
// ext_bus_ch0_ctrl fields
// ************************************************
`define BSC_EC_EN             0
`define BSC_EC_SP_LO          1
`define BSC_EC_PCI_BOOT       3
`define BSC_EC_RSVD           4

// ************************************************
// status fields and reset values
// ************************************************
`define BSC_ST_TEST_LO        0
`define BSC_ST_SYS_DONE       3
`define BSC_ST_CG_DONE        4
`define BSC_SYS_FIELD_RST     11'h7FF
`define BSC_CG_FIELD_RST      4'hF
`define BSC_PCI_BOOT_PAT      3'h3

`endif

// *** design/bsc_strap_pad.v ***
// Strap input pads with internal pull-up resolution
`timescale 1ns/1ns
`default_nettype none

module bsc_strap_pad #(
	parameter W = 15
) (
	input  wire [W-1:0] pad_level,
	input  wire [W-1:0] pad_driven,
	output wire [W-1:0] strap_level
);

	// Undriven pin floats high through the pull-up
	assign strap_level = (pad_driven & pad_level) | ~pad_driven;

endmodule // bsc_strap_pad

`default_nettype wire

// *** design/bsc_top.v ***
// Boot strap capture block with APB register view
`timescale 1ns/1ns
`default_nettype none
`include "bsc_regs.vh"

// How it works
// - Strap levels sampled first edge after reset release; high stores 1, low 0.
// - Every strap has a pull-up; an undriven strap reads as 1.
// - Address line 19 latched on system reset into PCI role field.
// - Address line 18 latched on system reset into shared pin select A.
// - Lines 14:13 latched on clock-gen reset into system clock speed field.
// - Address line 12 latched on system reset into endian field.
// - Lines 11:10 latched on clock-gen reset into PCI clock divide field.
// - Chip config bit 12 resets to zero regardless of straps.
// - Address line 9 latched on system reset into shared pin select B.
// - Lines 8:6 give channel 0 boot enable and clock speed.
// - Pattern LHH boots over PCI; LHL, LLH, LLL are reserved.
// - Address line 5 latched on system reset into SDRAM drive setting.
module bsc_top #(
	parameter AW = 12
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          clock_gen_reset_n,
	input  wire [AW-1:0] paddr,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	input  wire [14:0]   strap_pad_level,
	input  wire [14:0]   strap_pad_driven,
	output wire          pci_role_select,
	output wire          shared_pin_select_a,
	output wire          shared_pin_select_b,
	output wire          endian_big,
	output wire [1:0]    sys_clock_speed,
	output wire [1:0]    pci_clock_divide,
	output wire          ch0_boot_enable,
	output wire [1:0]    ch0_clock_speed,
	output reg           boot_from_pci,
	output reg           boot_pattern_reserved,
	output reg           sdram_drive_16ma
);

	// ************************************************
	// Strap pads and capture
	// ************************************************
	wire [14:0] strap;
	wire [10:0] sys_strap;
	wire [10:0] sys_field;
	wire [3:0]  cg_strap;
	wire [3:0]  cg_field;
	wire        sys_done;
	wire        cg_done;

	bsc_strap_pad #(
		.W(15)
	) u_pad (
		.pad_level  (strap_pad_level),
		.pad_driven (strap_pad_driven),
		.strap_level(strap)
	);

	// System reset group: role, sel A, test, endian, sel B, ch0, drive
	assign sys_strap = {strap[`BSC_S_PCI_ROLE],
	                    strap[`BSC_S_SEL_A],
	                    strap[`BSC_S_TEST_HI:`BSC_S_TEST_LO],
	                    strap[`BSC_S_ENDIAN],
	                    strap[`BSC_S_SEL_B],
	                    strap[`BSC_S_CH0_EN:`BSC_S_CH0_SP_LO],
	                    strap[`BSC_S_DRIVE]};

	// Clock generator group: system speed, PCI divide
	assign cg_strap = {strap[`BSC_S_SYS_SP_HI:`BSC_S_SYS_SP_LO],
	                   strap[`BSC_S_PCI_DIV_HI:`BSC_S_PCI_DIV_LO]};

	bsc_capture #(
		.W        (11),
		.RESET_VAL(`BSC_SYS_FIELD_RST)
	) u_sys_cap (
		.clk    (pclk),
		.rst_n  (presetn),
		.strap  (sys_strap),
		.field_q(sys_field),
		.done_q (sys_done)
	);

	// Own reset only, so a system reset leaves these alone
	bsc_capture #(
		.W        (4),
		.RESET_VAL(`BSC_CG_FIELD_RST)
	) u_cg_cap (
		.clk    (pclk),
		.rst_n  (clock_gen_reset_n),
		.strap  (cg_strap),
		.field_q(cg_field),
		.done_q (cg_done)
	);

	// ************************************************
	// Captured field views
	// ************************************************
	wire [2:0] test_straps;
	wire       drive_cap;

	assign pci_role_select     = sys_field[10];
	assign shared_pin_select_a = sys_field[9];
	assign test_straps         = sys_field[8:6];
	assign endian_big          = sys_field[5];
	assign shared_pin_select_b = sys_field[4];
	assign ch0_boot_enable     = sys_field[3];
	assign ch0_clock_speed     = sys_field[2:1];
	assign drive_cap           = sys_field[0];
	assign sys_clock_speed     = cg_field[3:2];
	assign pci_clock_divide    = cg_field[1:0];

	// ************************************************
	// Boot pattern decode
	// ************************************************
	function is_pci_boot;
		input [2:0] pat;
		begin
			is_pci_boot = (pat == `BSC_PCI_BOOT_PAT);
		end
	endfunction

	function is_rsvd_boot;
		input [2:0] pat;
		begin
			is_rsvd_boot = ~pat[2] & (pat != `BSC_PCI_BOOT_PAT);
		end
	endfunction

	// ************************************************
	// Software controls
	// ************************************************
	reg ovr_en_q;
	reg ovr_val_q;

	wire [2:0] boot_pat;

	assign boot_pat = sys_field[3:1];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_from_pci <= 1'b0;
		end else begin
			boot_from_pci <= is_pci_boot(boot_pat);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_pattern_reserved <= 1'b0;
		end else begin
			boot_pattern_reserved <= is_rsvd_boot(boot_pat);
		end
	end

	// Software may override the drive without touching the captured field
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdram_drive_16ma <= 1'b1;
		end else begin
			sdram_drive_16ma <= ovr_en_q ? ovr_val_q : drive_cap;
		end
	end

	// ************************************************
	// Register decode
	// ************************************************
	localparam [3:0] SEL_NONE = 4'h0;
	localparam [3:0] SEL_CHIP = 4'h1;
	localparam [3:0] SEL_PIN  = 4'h2;
	localparam [3:0] SEL_EXT  = 4'h4;
	localparam [3:0] SEL_STAT = 4'h8;

	// One-hot select, all zero for an unmapped address
	function [3:0] reg_decode;
		input [AW-1:0] a;
		begin
			case (a)
				`BSC_CHIP_CONFIG_OFS: begin
					reg_decode = SEL_CHIP;
				end
				`BSC_PIN_CONFIG_OFS: begin
					reg_decode = SEL_PIN;
				end
				`BSC_EXT_CH0_OFS: begin
					reg_decode = SEL_EXT;
				end
				`BSC_STATUS_OFS: begin
					reg_decode = SEL_STAT;
				end
				default: begin
					reg_decode = SEL_NONE;
				end
			endcase
		end
	endfunction

	// ************************************************
	// APB slave
	// ************************************************
	wire       access;
	wire       wr_en;
	wire       rd_en;
	wire [3:0] sel;
	wire       hit;
	wire       wr_chip;
	wire       wr_pin;
	reg [31:0] rd_d;

	assign access  = psel & penable & ~pready;
	assign wr_en   = access & pwrite;
	assign rd_en   = access & ~pwrite;
	assign sel     = reg_decode(paddr);
	assign hit     = |sel;
	assign wr_chip = wr_en & sel[0];
	assign wr_pin  = wr_en & sel[1];

	// ************************************************
	// Register writes
	// ************************************************
	// Read-only registers and unmapped addresses ignore writes
	// Override enable in chip_config_reg
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_en_q <= 1'b0;
		end else if (wr_chip) begin
			ovr_en_q <= pwdata[`BSC_CC_OVR_EN];
		end
	end

	// Override value in pin_config_reg
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_val_q <= 1'b0;
		end else if (wr_pin) begin
			ovr_val_q <= pwdata[`BSC_PC_OVR_VAL];
		end
	end

	// ************************************************
	// Read words
	// ************************************************
	// Unused bits read as zero
	reg [31:0] chip_cfg_word;
	reg [31:0] pin_cfg_word;
	reg [31:0] ext_ch0_word;
	reg [31:0] status_word;

	always @* begin
		chip_cfg_word                                          = 32'h00000000;
		chip_cfg_word[`BSC_CC_ENDIAN]                          = endian_big;
		chip_cfg_word[`BSC_CC_SYS_SP_LO+1:`BSC_CC_SYS_SP_LO]   = sys_clock_speed;
		chip_cfg_word[`BSC_CC_PCI_DIV_LO+1:`BSC_CC_PCI_DIV_LO] = pci_clock_divide;
		chip_cfg_word[`BSC_CC_PCI_ROLE]                        = pci_role_select;
		chip_cfg_word[`BSC_CC_OVR_EN]                          = ovr_en_q;
	end

	always @* begin
		pin_cfg_word                  = 32'h00000000;
		pin_cfg_word[`BSC_PC_SEL_A]   = shared_pin_select_a;
		pin_cfg_word[`BSC_PC_SEL_B]   = shared_pin_select_b;
		pin_cfg_word[`BSC_PC_DRIVE]   = drive_cap;
		pin_cfg_word[`BSC_PC_OVR_VAL] = ovr_val_q;
	end

	always @* begin
		ext_ch0_word                                = 32'h00000000;
		ext_ch0_word[`BSC_EC_EN]                    = ch0_boot_enable;
		ext_ch0_word[`BSC_EC_SP_LO+1:`BSC_EC_SP_LO] = ch0_clock_speed;
		ext_ch0_word[`BSC_EC_PCI_BOOT]              = boot_from_pci;
		ext_ch0_word[`BSC_EC_RSVD]                  = boot_pattern_reserved;
	end

	always @* begin
		status_word                                    = 32'h00000000;
		status_word[`BSC_ST_TEST_LO+2:`BSC_ST_TEST_LO] = test_straps;
		status_word[`BSC_ST_SYS_DONE]                  = sys_done;
		status_word[`BSC_ST_CG_DONE]                   = cg_done;
	end

	// ************************************************
	// Read mux
	// ************************************************
	always @* begin
		rd_d = 32'h00000000;
		case (sel)
			SEL_CHIP: begin
				rd_d = chip_cfg_word;
			end
			SEL_PIN: begin
				rd_d = pin_cfg_word;
			end
			SEL_EXT: begin
				rd_d = ext_ch0_word;
			end
			SEL_STAT: begin
				rd_d = status_word;
			end
			default: begin
				rd_d = 32'h00000000;
			end
		endcase
	end

	// ************************************************
	// Bus response
	// ************************************************
	// One wait state: pready rises on the first access-phase edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= access;
		end
	end

	// Error only for an unmapped address
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= access & ~hit;
		end
	end

	// Read data held until the next read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			prdata <= rd_d;
		end
	end

endmodule // bsc_top

`default_nettype wire

// *** test/boot_strap_capture_test.sv ***
// Self-checking bench for the boot strap capture block
`timescale 1ns/1ns
`default_nettype none
module boot_strap_capture_test;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        clock_gen_reset_n = 0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [31:0] pwdata = 32'h0;
	logic [14:0] pull_down = 15'h0000;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         sdram_drive_16ma;
	wire  [14:0] strap_pad_level;
	wire  [14:0] strap_pad_driven;
	int          bad_count = 0;
	int          n_tests = 0;
	always #4 pclk = ~pclk;
	bsc_strap_board board (.pclk, .pull_down, .pad_level(strap_pad_level), .pad_driven(strap_pad_driven));
	bsc_top dut (.pclk, .presetn, .clock_gen_reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .strap_pad_level, .strap_pad_driven, .pci_role_select(), .shared_pin_select_a(),
		.shared_pin_select_b(), .endian_big(), .sys_clock_speed(), .pci_clock_divide(), .ch0_boot_enable(),
		.ch0_clock_speed(), .boot_from_pci(), .boot_pattern_reserved(), .sdram_drive_16ma);
	// ****************
	// Shared tasks
	// ****************
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1) begin
			bad_count++;
			print_verdict;
		end
	endtask
	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		logic        er;
		apb(0, a, 32'h0, r, er);
		chk(nm, e, r);
	endtask
	task automatic rst(input logic cg);
		@(posedge pclk);
		presetn <= 0;
		if (cg) clock_gen_reset_n <= 0;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		clock_gen_reset_n <= 1;
		repeat (2) @(posedge pclk);
	endtask
	function automatic logic [31:0] cc(input logic [14:0] s, input logic [14:0] c);
		return {26'h0, s[14], c[6:5], c[9:8], s[7]};
	endfunction
	// ****************
	// Scenarios
	// ****************
	task automatic t_capture(input logic [14:0] e);
		pull_down <= ~e;
		rst(1);
		rdchk("chip_config", 12'h000, cc(e, e));
		rdchk("pin_config", 12'h004, {29'h0, e[0], e[4], e[13]});
		rdchk("ext_ch0", 12'h008, {27'h0, !e[3] && e[2:1] != 2'h3, e[3:1] == 3'h3, e[2:1], e[3]});
		rdchk("status", 12'h00C, 32'h0000001F);
	endtask
	task automatic t_hold;
		t_capture(15'h1C00);
		pull_down <= 15'h0000;
		repeat (6) @(posedge pclk);
		rdchk("held", 12'h000, cc(15'h1C00, 15'h1C00));
		rst(0);
		rdchk("sys_only", 12'h000, cc(15'h7FFF, 15'h1C00));
	endtask
	task automatic t_regs;
		logic [31:0] r;
		logic        er;
		t_capture(15'h7FFE);
		apb(1, 12'h000, 32'hFFFFFFFF, r, er);
		apb(1, 12'h004, 32'h00000008, r, er);
		apb(1, 12'h008, 32'hFFFFFFFF, r, er);
		rdchk("cfg_ovr", 12'h000, 32'h0000103F);
		rdchk("pin_ovr", 12'h004, 32'h0000000B);
		rdchk("ext_ro", 12'h008, 32'h00000007);
		chk("drive_ovr", 32'h1, {31'h0, sdram_drive_16ma});
		apb(0, 12'h010, 32'h0, r, er);
		chk("unmapped_err", 32'h1, {31'h0, er});
		chk("unmapped_data", 32'h0, r);
		rst(1);
		rdchk("cfg_clear", 12'h000, 32'h0000003F);
	endtask
	initial begin
		logic [2:0] k;
		for (int i = 0; i < 8; i++) begin
			k = i[2:0];
			t_capture({k[0], k[1], 3'h7, k[1:0], k[2], ~k[1:0], k[0], k, ~k[0]});
		end
		t_hold;
		t_regs;
		print_verdict;
	end
endmodule // boot_strap_capture_test
`default_nettype wire

// *** test/bsc_checker.sv ***
// Assertions on strap capture fields and register handshake
`timescale 1ns/1ns
`default_nettype none
module bsc_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clock_gen_reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic [14:0] strap_pad_level,
	input wire logic [14:0] strap_pad_driven,
	input wire logic        pci_role_select,
	input wire logic        shared_pin_select_a,
	input wire logic        shared_pin_select_b,
	input wire logic        endian_big,
	input wire logic [1:0]  sys_clock_speed,
	input wire logic [1:0]  pci_clock_divide,
	input wire logic        ch0_boot_enable,
	input wire logic [1:0]  ch0_clock_speed,
	input wire logic        boot_from_pci,
	input wire logic        boot_pattern_reserved,
	input wire logic        sdram_drive_16ma
);
	// ****************
	// Helpers
	// ****************
	// Floating straps read high
	wire [14:0] eff = strap_pad_level | ~strap_pad_driven;
	wire [6:0]  sys_f = {pci_role_select, shared_pin_select_a, endian_big, shared_pin_select_b,
		ch0_boot_enable, ch0_clock_speed};
	wire [3:0]  cg_f = {sys_clock_speed, pci_clock_divide};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_sys_rel; $rose(presetn); endsequence
	sequence s_sys_up; presetn [*3]; endsequence
	sequence s_cg_up; clock_gen_reset_n [*3]; endsequence
	// ****************
	// Assertions
	// ****************
	a_sys_capture: assert property (s_sys_rel |=> sys_f == $past({eff[14:13], eff[7], eff[4:1]}))
		else $error("system strap fields wrong");
	a_cg_capture: assert property (@(posedge pclk) disable iff (!clock_gen_reset_n)
		$rose(clock_gen_reset_n) |=> cg_f == $past({eff[9:8], eff[6:5]})) else $error("clock strap fields wrong");
	a_sys_hold: assert property (s_sys_up |-> $stable(sys_f)) else $error("system fields moved");
	a_cg_hold: assert property (@(posedge pclk) disable iff (!clock_gen_reset_n)
		s_cg_up |-> $stable(cg_f)) else $error("clock fields moved");
	a_pci_boot: assert property (s_sys_up |-> boot_from_pci == ({ch0_boot_enable, ch0_clock_speed} == 3'h3))
		else $error("pci boot flag wrong");
	a_rsvd_flag: assert property (s_sys_up |->
		boot_pattern_reserved == (!ch0_boot_enable && ch0_clock_speed != 2'h3)) else $error("reserved flag wrong");
	a_drive_init: assert property (s_sys_rel ##1 1 |=> sdram_drive_16ma == $past(eff[0], 2))
		else $error("drive setting wrong");
	a_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready) else $error("ready timing");
endmodule // bsc_checker
bind bsc_top bsc_checker u_chk (.pclk, .presetn, .clock_gen_reset_n, .psel, .penable, .pready, .strap_pad_level,
	.strap_pad_driven, .pci_role_select, .shared_pin_select_a, .shared_pin_select_b, .endian_big, .sys_clock_speed,
	.pci_clock_divide, .ch0_boot_enable, .ch0_clock_speed, .boot_from_pci, .boot_pattern_reserved, .sdram_drive_16ma);
`default_nettype wire

// *** test/bsc_strap_board.sv ***
// Board strap resistors: pull-downs only, floating pins wander
`timescale 1ns/1ns
`default_nettype none
module bsc_strap_board (
	input wire logic        pclk,
	input wire logic [14:0] pull_down,
	output logic     [14:0] pad_level,
	output logic     [14:0] pad_driven
);
	logic [14:0] junk_q = 15'h2AAA;
	always @(posedge pclk) junk_q <= ~junk_q;
	assign pad_driven = pull_down & 15'h63FF;
	assign pad_level = ~pad_driven & junk_q;
endmodule // bsc_strap_board
`default_nettype wire
